// file: verilog/rxtsb_pkg.sv
package rxtsb_pkg;
  // widths of the header and sideband fields, and bar counts
  localparam int BAR_CODE_W = 3;
  localparam int BAR_NUM    = 6;   // bars 0..5, three even/odd pairs
  localparam int PAIR_NUM   = 3;
  localparam int PF_W       = 2;
  localparam int VF_OFS_W   = 12;
  localparam int VF_CNT_W   = 16;
  localparam int FMT_W      = 3;
  localparam int TYPE_W     = 5;
  // buffer geometry and stream timing
  localparam int BUF_DEPTH  = 2;
  localparam int PTR_W      = 1;
  localparam int CNT_W      = 2;
  localparam int READY_LAT  = 2;   // cycles from sink ready to a transfer
  // field positions and header codes
  localparam int FMT_DATA_BIT  = 1;   // set when the packet carries data
  localparam logic [TYPE_W-1:0] TYPE_MEM      = 5'h00;
  localparam logic [TYPE_W-1:0] TYPE_MEM_LK   = 5'h01;
  localparam logic [TYPE_W-1:0] TYPE_CPL      = 5'h0a;
  localparam logic [TYPE_W-1:0] TYPE_CPL_LK   = 5'h0b;
  localparam logic [TYPE_W-1:0] TYPE_FETCHADD = 5'h0c;
  localparam logic [TYPE_W-1:0] TYPE_SWAP     = 5'h0d;
  localparam logic [TYPE_W-1:0] TYPE_CAS      = 5'h0e;
  localparam logic [1:0]        TYPE_MSG_HI   = 2'h2;  // type[4:3] of a message
  localparam logic [2:0]        MSG_ROUTE_ID  = 3'h2;  // type[2:0] routed by id
  // reset values and fill count levels
  localparam logic [BAR_CODE_W-1:0] BAR_CODE_RST = 3'h0;
  localparam logic [PF_W-1:0]       PF_RST       = 2'h0;
  localparam logic [VF_OFS_W-1:0]   VF_OFS_RST   = 12'h000;
  localparam logic [CNT_W-1:0]      CNT_FULL     = 2'h2;
  localparam logic [CNT_W-1:0]      CNT_EMPTY    = 2'h0;

  // target identification carried alongside each beat
  typedef struct packed {
    logic [BAR_CODE_W-1:0] bar_code;
    logic [PF_W-1:0]       pf;
    logic                  is_vf;
    logic [VF_OFS_W-1:0]   vf_ofs;
  } rxtsb_side_s;

  // one buffered beat
  typedef struct packed {
    logic        sop;
    logic        eop;
    logic        bar_ok;   // packet type gives a meaningful bar code
    logic        routed;   // packet type gives a meaningful function id
    rxtsb_side_s side;
  } rxtsb_beat_s;

  // packet framing on the input side
  typedef enum logic [0:0] {
    PKT_IDLE = 1'b0,
    PKT_BODY = 1'b1
  } rxtsb_pkt_e;
endpackage

// file: verilog/rxtsb_sideband.sv
// Notes on behaviour
// - drive 3-bit code of the matching bar
// - bar code meaningful only for memory, atomics
// - code valid on first beat with valid
// - codes 0,2,4 name even bar or pair
// - odd codes only for 32-bit; 6-7 reserved
// - vf flag selects pf or vf bar space
// - 2-bit physical function of the target
// - for a vf, report its parent pf
// - flag high when target is a vf
// - 12-bit vf offset while flag high
// - sink ready enables transfer two cycles later
`timescale 1ns/100ps
module rxtsb_sideband (
  input  wire logic                           sys_clk,
  input  wire logic                           nrst,
  // beats from the transaction layer
  input  wire logic                           tl_valid,
  output logic                                tl_ready,
  input  wire logic                           tl_sop,
  input  wire logic                           tl_eop,
  input  wire logic [rxtsb_pkg::FMT_W-1:0]    tl_fmt,
  input  wire logic [rxtsb_pkg::TYPE_W-1:0]   tl_type,
  input  wire logic [rxtsb_pkg::BAR_NUM-1:0]  tl_bar_hit,
  input  wire logic [rxtsb_pkg::PAIR_NUM-1:0] bar_pair_64,
  input  wire logic                           tl_func_is_vf,
  input  wire logic [rxtsb_pkg::PF_W-1:0]     tl_pf,
  input  wire logic [rxtsb_pkg::VF_OFS_W-1:0] tl_vf_ofs,
  input  wire logic [rxtsb_pkg::VF_CNT_W-1:0] tl_vf_count,
  // receive stream toward the application
  input  wire logic                           rx_stream_sink_ready,
  output logic                                rx_stream_beat_valid,
  output logic                                rx_stream_packet_start,
  output logic                                rx_stream_packet_end,
  output logic [rxtsb_pkg::BAR_CODE_W-1:0]    rx_bar_match_code,
  output logic [rxtsb_pkg::PF_W-1:0]          rx_target_phys_func,
  output logic                                rx_target_is_virtual,
  output logic [rxtsb_pkg::VF_OFS_W-1:0]      rx_target_virt_offset
);

  rxtsb_pkg::rxtsb_beat_s              mem_r [rxtsb_pkg::BUF_DEPTH]; // buffer storage
  rxtsb_pkg::rxtsb_beat_s              dec_beat;     // decoded input beat
  rxtsb_pkg::rxtsb_beat_s              hdr_r;        // values of the current packet
  rxtsb_pkg::rxtsb_beat_s              rd_beat;      // head of the buffer
  rxtsb_pkg::rxtsb_pkt_e               pkt_r;        // input framing state
  logic [rxtsb_pkg::PTR_W-1:0]         wr_ptr_r;     // next entry to fill
  logic [rxtsb_pkg::PTR_W-1:0]         rd_ptr_r;     // next entry to send
  logic [rxtsb_pkg::CNT_W-1:0]         cnt_r;        // entries in use
  logic [rxtsb_pkg::READY_LAT-1:0]     rdy_pipe_r;   // sink ready history
  logic                                push;         // beat taken in
  logic                                pop;          // beat sent out
  logic                                is_mem_req;   // memory read or write
  logic                                is_atomic;    // atomic op request
  logic                                is_cpl;       // completion
  logic                                is_id_msg;    // message routed by id
  logic [rxtsb_pkg::BAR_CODE_W-1:0]    bar_enc;      // encoded bar hit

  // packet type decode from the header of the first beat
  always_comb begin
    is_mem_req = (tl_type == rxtsb_pkg::TYPE_MEM) || (tl_type == rxtsb_pkg::TYPE_MEM_LK);
    is_atomic  = tl_fmt[rxtsb_pkg::FMT_DATA_BIT] &&
                 ((tl_type == rxtsb_pkg::TYPE_FETCHADD) ||
                  (tl_type == rxtsb_pkg::TYPE_SWAP) ||
                  (tl_type == rxtsb_pkg::TYPE_CAS));
    is_cpl     = (tl_type == rxtsb_pkg::TYPE_CPL) || (tl_type == rxtsb_pkg::TYPE_CPL_LK);
    is_id_msg  = (tl_type[4:3] == rxtsb_pkg::TYPE_MSG_HI) &&
                 (tl_type[2:0] == rxtsb_pkg::MSG_ROUTE_ID);
  end

  // bar hit encoder; lowest hit wins. an odd hit inside a 64-bit pair is
  // folded onto the even code, so a reserved code is never produced
  always_comb begin
    bar_enc = rxtsb_pkg::BAR_CODE_RST;
    for (int i = rxtsb_pkg::BAR_NUM - 1; i >= 0; i--) begin
      if (tl_bar_hit[i]) begin
        if (i[0] && bar_pair_64[i/2]) begin
          bar_enc = rxtsb_pkg::BAR_CODE_W'(i - 1);
        end else begin
          bar_enc = rxtsb_pkg::BAR_CODE_W'(i);
        end
      end
    end
  end

  // fill the sideband of a start beat; fields that carry no meaning for the
  // packet type are forced to zero so the application never sees stale ids
  always_comb begin
    dec_beat        = '0;
    dec_beat.sop    = tl_sop;
    dec_beat.eop    = tl_eop;
    dec_beat.bar_ok = is_mem_req || is_atomic;
    dec_beat.routed = is_mem_req || is_atomic || is_cpl || is_id_msg;
    if (dec_beat.bar_ok) begin
      dec_beat.side.bar_code = bar_enc;
    end
    if (dec_beat.routed) begin
      dec_beat.side.pf    = tl_pf;
      dec_beat.side.is_vf = tl_func_is_vf;
      if (tl_func_is_vf) begin
        dec_beat.side.vf_ofs = tl_vf_ofs;
      end
    end
    if (!tl_sop) begin
      // later beats repeat the values captured at the start beat
      dec_beat.bar_ok = hdr_r.bar_ok;
      dec_beat.routed = hdr_r.routed;
      dec_beat.side   = hdr_r.side;
    end
  end

  // buffer handshakes; input ready only needs room, so a stall by the
  // sink backs up here without loss, at the cost of no same-cycle bypass
  always_comb begin
    tl_ready = (cnt_r != rxtsb_pkg::CNT_FULL);
    push     = tl_valid && tl_ready;
    rd_beat  = mem_r[rd_ptr_r];
    pop      = (cnt_r != rxtsb_pkg::CNT_EMPTY) && rdy_pipe_r[rxtsb_pkg::READY_LAT-1];
  end

  // sink ready delay line for the two-cycle ready latency
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_pipe_r <= '0;
    end else begin
      rdy_pipe_r <= {rdy_pipe_r[rxtsb_pkg::READY_LAT-2:0], rx_stream_sink_ready};
    end
  end

  // header hold and framing: capture at each accepted start beat. the
  // framing state only tracks whether a packet is open; it lets the checks
  // below catch a continuation beat that arrives with no packet to extend
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hdr_r <= '0;
      pkt_r <= rxtsb_pkg::PKT_IDLE;
    end else if (push) begin
      if (tl_sop) begin
        hdr_r <= dec_beat;
      end
      case (pkt_r)
        rxtsb_pkg::PKT_IDLE: begin
          // a single-beat packet never leaves idle
          pkt_r <= (tl_sop && !tl_eop) ? rxtsb_pkg::PKT_BODY : rxtsb_pkg::PKT_IDLE;
        end
        rxtsb_pkg::PKT_BODY: begin
          pkt_r <= tl_eop ? rxtsb_pkg::PKT_IDLE : rxtsb_pkg::PKT_BODY;
        end
        default: begin
          pkt_r <= rxtsb_pkg::PKT_IDLE;
        end
      endcase
    end
  end

  // storage entries, written at the fill pointer
  for (genvar e = 0; e < rxtsb_pkg::BUF_DEPTH; e++) begin : g_entry
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        mem_r[e] <= '0;
      end else if (push && (wr_ptr_r == rxtsb_pkg::PTR_W'(e))) begin
        mem_r[e] <= dec_beat;
      end
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= rxtsb_pkg::CNT_EMPTY;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      case ({push, pop})
        2'h2:    cnt_r <= cnt_r + 2'h1;
        2'h1:    cnt_r <= cnt_r - 2'h1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // stream outputs; sideband comes straight from the stored entry
  always_comb begin
    rx_stream_beat_valid   = pop;
    rx_stream_packet_start = rd_beat.sop;
    rx_stream_packet_end   = rd_beat.eop;
    rx_bar_match_code      = rd_beat.side.bar_code;
    rx_target_phys_func    = rd_beat.side.pf;
    rx_target_is_virtual   = rd_beat.side.is_vf;
    rx_target_virt_offset  = rd_beat.side.vf_ofs;
  end

  // helper: function number of the last start beat sent
  logic [rxtsb_pkg::PF_W-1:0] last_pf_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_pf_r <= rxtsb_pkg::PF_RST;
    end else if (pop && rd_beat.sop) begin
      last_pf_r <= rd_beat.side.pf;
    end
  end

  // helper: whole sideband of the last start beat sent, so that later beats
  // of the same packet can be held against it field by field
  rxtsb_pkg::rxtsb_side_s last_side_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_side_r <= '0;
    end else if (pop && rd_beat.sop) begin
      last_side_r <= rd_beat.side;
    end
  end

  // checks below watch what this block drives; the buffer count and
  // framing state are read directly so a slip in the pointer logic shows
  // up at the cycle it happens, not beats later at the far side

  // ready granted, and two cycles later something waits in the buffer
  sequence s_ready_then_data;
    rx_stream_sink_ready ##2 (cnt_r != rxtsb_pkg::CNT_EMPTY);
  endsequence

  // first beat of a packet leaving the buffer
  sequence s_start_beat;
    rx_stream_beat_valid && rx_stream_packet_start;
  endsequence

  // a continuation beat leaving the buffer
  sequence s_tail_beat;
    rx_stream_beat_valid && !rx_stream_packet_start;
  endsequence

  AST_READY_LATENCY: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    rx_stream_beat_valid |-> $past(rx_stream_sink_ready, 2))
    else $error("beat sent without ready two cycles before");

  AST_DRAIN_ON_READY: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_ready_then_data |-> rx_stream_beat_valid)
    else $error("buffered beat held back while ready was granted");

  AST_NO_RESERVED_CODE: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_start_beat |-> (rx_bar_match_code < 3'h6))
    else $error("reserved bar code driven");

  AST_BAR_ZERO_OTHER: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_start_beat ##0 !rd_beat.bar_ok |-> (rx_bar_match_code == 3'h0))
    else $error("bar code driven for a non-memory packet");

  AST_PAIR_EVEN: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (tl_valid && tl_sop && dec_beat.bar_ok && bar_enc[0]) |-> !bar_pair_64[bar_enc[2:1]])
    else $error("odd code produced inside a 64-bit pair");

  AST_OFS_ONLY_VF: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rx_stream_beat_valid && !rx_target_is_virtual) |-> (rx_target_virt_offset == 12'h000))
    else $error("vf offset driven while the target is a pf");

  AST_ID_UNROUTED: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rx_stream_beat_valid && !rd_beat.routed) |->
      (!rx_target_is_virtual && rx_target_phys_func == 2'h0))
    else $error("function id driven for an unrouted packet");

  AST_PF_HELD: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (rx_stream_beat_valid && !rx_stream_packet_start) |-> (rx_target_phys_func == last_pf_r))
    else $error("function number changed inside a packet");

  AST_FULL_STALL: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (cnt_r == rxtsb_pkg::CNT_FULL && !pop) |-> !tl_ready ##1 (cnt_r == rxtsb_pkg::CNT_FULL))
    else $error("buffer accepted a beat while full");

  AST_TAKE_KEEPS: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (tl_valid && cnt_r != rxtsb_pkg::CNT_FULL) |=> (cnt_r != rxtsb_pkg::CNT_EMPTY))
    else $error("accepted beat lost from the buffer");

  AST_BODY_IN_PACKET: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (push && !tl_sop) |-> (pkt_r == rxtsb_pkg::PKT_BODY))
    else $error("continuation beat taken outside a packet");

  AST_SIDE_HELD: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_tail_beat |->
      ({rx_bar_match_code, rx_target_is_virtual, rx_target_virt_offset} ==
       {last_side_r.bar_code, last_side_r.is_vf, last_side_r.vf_ofs}))
    else $error("sideband changed inside a packet");

endmodule

// file: dv/rxtsb_sink_model.sv
`timescale 1ns/100ps
// application sink: throttles the receive stream with a changing ready pattern
module rxtsb_sink_model (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic hold_off,            // forces a long stall
  output logic      rx_stream_sink_ready
);
  logic [7:0] lfsr_r;                    // stall pattern, moves every cycle
  // ready moves just after the edge; the beat it allows lands two cycles later
  // the sink never looks at the bar code of a non memory packet
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_r               <= 8'h5a;
      rx_stream_sink_ready <= 1'b0;
    end else begin
      lfsr_r               <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      rx_stream_sink_ready <= #1 !hold_off && (lfsr_r[1:0] != 2'h0);
    end
  end
endmodule

// file: dv/rx_tlp_target_sideband_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module rx_tlp_target_sideband_test;
  logic        sys_clk = 1'b0, nrst = 1'b0, hold_off = 1'b0;   // clock, reset, stall
  logic        tl_valid = 1'b0, tl_sop = 1'b0, tl_eop = 1'b0, tl_func_is_vf = 1'b0;
  logic [2:0]  tl_fmt = 3'h0, bar_pair_64 = 3'h0;
  logic [4:0]  tl_type = 5'h00;
  logic [5:0]  tl_bar_hit = 6'h00;
  logic [1:0]  tl_pf = 2'h0, rdy_h = 2'h0;                      // rdy_h: ready history
  logic [11:0] tl_vf_ofs = 12'h000;
  logic [15:0] tl_vf_count = 16'h0000;
  logic        tl_ready, rx_stream_sink_ready, rx_stream_beat_valid, rx_stream_packet_start;
  logic        rx_stream_packet_end, rx_target_is_virtual;
  logic [2:0]  rx_bar_match_code;
  logic [1:0]  rx_target_phys_func;
  logic [11:0] rx_target_virt_offset;
  logic [31:0] seed = 32'h920702f4;                            // xorshift state
  logic [19:0] exp_q[$];                                       // {sop, eop, sideband}
  logic [19:0] e;
  logic [4:0]  ty_tab[9] = '{5'h00, 5'h01, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h12, 5'h04};
  int          n_mismatch = 0, cmp_count = 0;

  rxtsb_sideband rxtsb_sideband_inst (.sys_clk(sys_clk), .nrst(nrst), .tl_valid(tl_valid),
    .tl_ready(tl_ready), .tl_sop(tl_sop), .tl_eop(tl_eop), .tl_fmt(tl_fmt), .tl_type(tl_type),
    .tl_bar_hit(tl_bar_hit), .bar_pair_64(bar_pair_64), .tl_func_is_vf(tl_func_is_vf),
    .tl_pf(tl_pf), .tl_vf_ofs(tl_vf_ofs), .tl_vf_count(tl_vf_count),
    .rx_stream_sink_ready(rx_stream_sink_ready), .rx_stream_beat_valid(rx_stream_beat_valid),
    .rx_stream_packet_start(rx_stream_packet_start), .rx_stream_packet_end(rx_stream_packet_end),
    .rx_bar_match_code(rx_bar_match_code), .rx_target_phys_func(rx_target_phys_func),
    .rx_target_is_virtual(rx_target_is_virtual), .rx_target_virt_offset(rx_target_virt_offset));
  rxtsb_sink_model rxtsb_sink_model_inst (.sys_clk(sys_clk), .nrst(nrst), .hold_off(hold_off),
    .rx_stream_sink_ready(rx_stream_sink_ready));

  always #10 sys_clk = ~sys_clk;                               // 50 MHz

  // next random word
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // sideband a packet should carry, from its start-beat header and target
  function automatic rxtsb_pkg::rxtsb_side_s exp_side(input logic [2:0] fmt,
      input logic [4:0] ty, input logic [5:0] hit, input logic [2:0] p64, input logic isvf,
      input logic [1:0] pf, input logic [11:0] ofs);
    rxtsb_pkg::rxtsb_side_s s;
    logic                   mem, rt;
    mem = (ty <= 5'h01) || (ty >= 5'h0c && ty <= 5'h0e && fmt[1]);
    rt  = mem || ty == 5'h0a || ty == 5'h0b || ty == 5'h12;
    s   = '0;
    // lowest hit wins; an odd bar paired into 64 bits reports the even code
    for (int i = 5; i >= 0; i--) begin
      if (hit[i]) s.bar_code = 3'(p64[i/2] ? (i & 6) : i);
    end
    if (!mem) s.bar_code = 3'h0;
    if (rt) begin
      s.pf     = pf;
      s.is_vf  = isvf;
      s.vf_ofs = isvf ? ofs : 12'h000;
    end
    return s;
  endfunction

  // send one packet; later beats carry junk fields that must not leak out
  task automatic send_pkt(input int nb, input logic [2:0] fmt, input logic [4:0] ty,
      input logic [5:0] hit);
    rxtsb_pkg::rxtsb_side_s s;
    for (int k = 0; k < nb; k++) begin
      seed          = xs(seed);
      tl_valid      = 1'b1;
      tl_sop        = (k == 0);
      tl_eop        = (k == nb - 1);
      tl_fmt        = (k == 0) ? fmt : seed[2:0];
      tl_type       = (k == 0) ? ty : seed[7:3];
      tl_bar_hit    = (k == 0) ? hit : seed[13:8];
      tl_func_is_vf = seed[14];
      tl_pf         = seed[16:15];
      tl_vf_ofs     = seed[28:17];
      if (k == 0) s = exp_side(fmt, ty, hit, bar_pair_64, seed[14], seed[16:15], seed[28:17]);
      exp_q.push_back({tl_sop, tl_eop, s});
      // ready only moves at the edge, so its value at the falling edge is what is sampled
      do @(negedge sys_clk); while (tl_ready !== 1'b1);
      @(posedge sys_clk);
      #1;
    end
  endtask

  // settled mid-cycle look at every outgoing beat
  always @(negedge sys_clk) begin
    if (nrst && rx_stream_beat_valid === 1'b1) begin
      `CHK("ready latency", 1'b1, rdy_h[1])
      if (exp_q.size() == 0) `CHK("extra beat", 1'b0, 1'b1)
      else begin
        e = exp_q.pop_front();
        `CHK("framing", e[19:18], {rx_stream_packet_start, rx_stream_packet_end})
        `CHK("bar code", e[17:15], rx_bar_match_code)
        `CHK("function", e[14:13], rx_target_phys_func)
        `CHK("vf flag", e[12], rx_target_is_virtual)
        `CHK("vf offset", e[11:0], rx_target_virt_offset)
      end
    end
    rdy_h <= {rdy_h[0], rx_stream_sink_ready};
  end

  // print counts and the verdict, then stop
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog sized well above the several hundred cycles the tests need
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    `CHK("reset state", 20'h80000, {tl_ready, rx_stream_beat_valid, rx_bar_match_code,
      rx_target_phys_func, rx_target_is_virtual, rx_target_virt_offset})
    repeat (5) @(posedge sys_clk);
    #1;
    nrst        = 1'b1;
    tl_vf_count = 16'h0040;
    // every packet kind with data, back to back, then a two-beat fetch-add without data
    for (int t = 0; t < 9; t++) send_pkt(1, 3'h2, ty_tab[t], 6'h01);
    send_pkt(2, 3'h0, 5'h0c, 6'h04);
    // each single bar hit, 32-bit and paired, plus no hit and every bar but bar 0 hit
    for (int p = 0; p < 2; p++) begin
      tl_valid    = 1'b0;
      @(posedge sys_clk);
      #1;
      bar_pair_64 = p ? 3'h7 : 3'h0;
      for (int i = 0; i < 6; i++) send_pkt(1, 3'h0, 5'h00, 6'(1 << i));
      send_pkt(1, 3'h2, 5'h01, 6'h00);
      send_pkt(1, 3'h2, 5'h0e, 6'h3e);
    end
    // random packets with idle gaps and a changing bar layout between them
    for (int n = 0; n < 200; n++) begin
      seed = xs(seed);
      if (seed[31]) begin
        tl_valid    = 1'b0;
        @(posedge sys_clk);
        #1;
        bar_pair_64 = seed[30:28];
      end
      send_pkt(int'(seed[1:0] % 3) + 1, seed[4:2], ty_tab[seed[8:5] % 9], seed[14:9]);
    end
    // long stall: drain first so no beat is stranded behind the stall,
    // then two beats fill the buffer and the source is refused
    tl_valid = 1'b0;
    while (exp_q.size() != 0) @(posedge sys_clk);
    #1;
    hold_off = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    send_pkt(1, 3'h0, 5'h00, 6'h10);
    send_pkt(1, 3'h2, 5'h0a, 6'h01);
    tl_valid = 1'b0;
    @(negedge sys_clk);
    `CHK("full refuses", 3'h2, {tl_ready, 2'(exp_q.size())})
    #11;
    hold_off = 1'b0;
    while (exp_q.size() != 0) @(posedge sys_clk);
    give_verdict();
  end
endmodule
